// [cst_pkg.sv]
// constants shared by the clock source and timewheel block
// assumes a single 40 MHz system clock and a 32-bit register bus
package cst_pkg;
   // ======================================================
   // clock and timing
   localparam int CLK_HZ = 40_000_000;
   localparam int LSO_FAST_HZ = 100_000;
   localparam int LSO_SLOW_HZ = 1_000;
   localparam int LSO_MID_DIV = 3;
   localparam int LSO_FAST_DIV = CLK_HZ / LSO_FAST_HZ;
   localparam int LSO_SLOW_DIV = LSO_FAST_HZ / LSO_SLOW_HZ;
   localparam int PLL_LOCK_US = 250;
   localparam int PLL_LOCK_CYC = PLL_LOCK_US * (CLK_HZ / 1_000_000);
   localparam int WATCH_HZ = 32_768;

   // ======================================================
   // register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PLL_DIV = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_SLOW_CFG = 8'h0C;
   localparam logic [7:0] REG_FAST_CFG = 8'h10;
   localparam logic [7:0] REG_COUNT = 8'h14;
   localparam logic [7:0] REG_DIV_BASE = 8'h40;
   localparam int NUM_DIG = 8;
   localparam int NUM_ANA = 4;
   localparam int NUM_DIV = 13;

   // ======================================================
   // field positions
   localparam int CTRL_FSEL_LSB = 0;
   localparam int CTRL_DSRC_LSB = 4;
   localparam int CTRL_PSRC_LSB = 6;
   localparam int CTRL_PLL_EN = 8;
   localparam int CTRL_DBL_EN = 9;
   localparam int PDIV_IN_LSB = 0;
   localparam int PDIV_FB_LSB = 8;
   localparam int STAT_LOCK = 0;
   localparam int STAT_DBL = 1;
   localparam int SW_SEL_LSB = 0;
   localparam int SW_WAKE_EN = 4;
   localparam int SW_IRQ_EN = 5;
   localparam int SW_CLR = 8;
   localparam int FW_TERM_LSB = 0;
   localparam int FW_WAKE_EN = 5;
   localparam int FW_IRQ_EN = 6;
   localparam int CNT_FAST_LSB = 16;
   localparam int DIV_SEL_LSB = 16;
   localparam int DIV_EN = 31;

   // ======================================================
   // encodings and reset values
   localparam logic [2:0] IMO_NUM_FREQ = 3'h6;
   localparam logic [1:0] SRC_IMO = 2'h0;
   localparam logic [1:0] SRC_FXTAL = 2'h1;
   localparam logic [1:0] SRC_FABRIC = 2'h2;
   localparam logic [1:0] SRC_BAD = 2'h3;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PDIV_RST = 32'h0000_0100;
   localparam logic [31:0] SLOW_RST = 32'h0000_0000;
   localparam logic [31:0] FAST_RST = 32'h0000_001F;
   localparam logic [31:0] DIV_RST = 32'h0000_0002;
endpackage

// [cst_clk_div.sv]
// one clock divider: 8-input source select and 16-bit divide
// assumes source ticks are one-cycle enables on the system clock
`timescale 1ns/100ps
`default_nettype none
module cst_clk_div (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic en_i, // divider enable
   input wire logic [7:0] src_ticks_i, // candidate source ticks
   input wire logic [2:0] sel_i, // source select
   input wire logic [15:0] div_i, // divide ratio
   output logic clk_o, // divided clock level
   output logic tick_o // pulse on each rising edge from a count wrap to zero
);
   import cst_pkg::*;

   logic [15:0] cnt_ff;
   logic clk_ff;
   logic tick_ff;
   logic in_tick;
   logic [15:0] ratio;
   logic [15:0] nxt_cnt;

   // ratios below two are taken as two
   always_comb begin
      in_tick = en_i & src_ticks_i[sel_i];
      ratio = (div_i < 16'h0002) ? 16'h0002 : div_i;
      nxt_cnt = (cnt_ff >= ratio - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
   end

   // output only ever changes from this flop, so it cannot glitch
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !en_i) begin
         cnt_ff <= 16'h0000;
         clk_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= in_tick && (nxt_cnt == 16'h0000);
         if (in_tick) begin
            cnt_ff <= nxt_cnt;
            clk_ff <= nxt_cnt < (ratio >> 1);
         end
      end
   end

   assign clk_o = clk_ff;
   assign tick_o = tick_ff;
endmodule
`default_nettype wire

// [cst_clock_core.sv]
// clock sources, pll control, low-speed clocks, timewheels, dividers
// assumes oscillator outputs arrive as one-cycle enables, synchronous
// Summary of operation
// - main oscillator frequency from six fixed values
// - doubler emits twice its input rate
// - doubler input picks oscillator, crystal or fabric
// - pll ratio from input and feedback dividers
// - pll reference picks oscillator, crystal or fabric
// - pll locks within 250 us of enable
// - lock bit readable and routed to fabric
// - low-speed oscillator gives 1, 33, 100 kHz
// - 33 kHz is 100 kHz divided by three
// - slow wheel: free 13-bit count at 1 kHz
// - slow wheel halts in hibernate and debug
// - software can clear the slow wheel
// - slow wheel periodic wake, optional interrupt
// - fast wheel: 5-bit at 100 kHz, programmable end
// - fast wheel wraps at end and wakes
// - fast wheel end raises enabled interrupt
// - watch crystal gives one-second interrupt
// - eight fabric clocks feed digital dividers directly
// - eight digital, four analog, one bus divider
// - divider selects, divides, resyncs, deglitches
`timescale 1ns/100ps
`default_nettype none
module cst_clock_core #(
   parameter int LOCK_CYCLES = cst_pkg::PLL_LOCK_CYC // pll lock wait
) (
   input wire logic clk_i, // 40 MHz system clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic [7:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   output logic [31:0] avs_readdata_o, // read data
   output logic avs_waitrequest_o, // stall
   input wire logic internal_main_osc_tick_i, // main osc tick
   input wire logic fast_crystal_osc_tick_i, // crystal osc tick
   input wire logic fabric_clk_tick_i, // primary fabric clock tick
   input wire logic [7:0] fabric_div_clk_i, // direct divider clocks
   input wire logic watch_crystal_osc_tick_i, // 32.768 kHz tick
   input wire logic hibernate_i, // hibernate mode
   input wire logic debug_halt_i, // cpu halted in debug
   output logic [2:0] internal_main_osc_freq_sel_o, // osc range
   output logic doubler_tick_o, // doubler tick
   output logic pll_tick_o, // pll tick
   output logic pll_lock_o, // lock to fabric
   output logic low_speed_clk_slow_o, // 1 kHz tick
   output logic low_speed_clk_mid_o, // 33 kHz tick
   output logic low_speed_clk_fast_o, // 100 kHz tick
   output logic slow_wake_o, // slow wheel wake pulse
   output logic slow_wake_irq_o, // slow wheel interrupt pulse
   output logic fast_wake_o, // fast wheel wake pulse
   output logic fast_wake_irq_o, // fast wheel interrupt pulse
   output logic rtc_second_irq_o, // one-second pulse
   output logic [7:0] dig_clk_o, // digital divider clocks
   output logic [3:0] ana_clk_o, // analog divider clocks
   output logic bus_clk_o // bus and cpu clock
);
   import cst_pkg::*;

   localparam logic [8:0] FAST_DIV_M1 = 9'(LSO_FAST_DIV - 1);
   localparam logic [6:0] SLOW_DIV_M1 = 7'(LSO_SLOW_DIV - 1);
   localparam logic [1:0] MID_DIV_M1 = 2'(LSO_MID_DIV - 1);
   localparam logic [14:0] WATCH_M1 = 15'(WATCH_HZ - 1);
   localparam logic [15:0] LOCK_M = 16'(LOCK_CYCLES);

   // ======================================================
   // register bus
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_fire;
   logic [31:0] ctrl_ff;
   logic [31:0] pdiv_ff;
   logic [31:0] slow_cfg_ff;
   logic [31:0] fast_cfg_ff;
   logic [31:0] div_ff [NUM_DIV];
   logic [12:0] slow_cnt_ff;
   logic [4:0] fast_cnt_ff;
   logic lock_ff;
   logic dbl_act_ff;

   // one wait state: every access completes on the second edge
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
   assign wr_fire = avs_write_i & ~avs_waitrequest_o;
   assign avs_readdata_o = rdata_ff;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (avs_address_i)
         REG_CTRL: nxt_rdata = ctrl_ff;
         REG_PLL_DIV: nxt_rdata = pdiv_ff;
         REG_STATUS: begin
            nxt_rdata[STAT_LOCK] = lock_ff;
            nxt_rdata[STAT_DBL] = dbl_act_ff;
         end
         REG_SLOW_CFG: nxt_rdata = slow_cfg_ff;
         REG_FAST_CFG: nxt_rdata = fast_cfg_ff;
         REG_COUNT: begin
            nxt_rdata[12:0] = slow_cnt_ff;
            nxt_rdata[CNT_FAST_LSB +: 5] = fast_cnt_ff;
         end
         default: begin
            for (int i = 0; i < NUM_DIV; i++) begin
               if (avs_address_i == REG_DIV_BASE + 8'(4 * i)) begin
                  nxt_rdata = div_ff[i];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read_i && !ack_ff) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ======================================================
   // control registers; illegal codes leave the old value in place
   logic pll_restart;
   logic slow_clr;
   assign slow_clr = wr_fire && (avs_address_i == REG_SLOW_CFG) && avs_writedata_i[SW_CLR];
   // dropping the enable clears lock on the same edge; a refused source code changes nothing
   assign pll_restart = wr_fire && ((avs_address_i == REG_PLL_DIV) ||
      (avs_address_i == REG_CTRL && (!avs_writedata_i[CTRL_PLL_EN] ||
      (avs_writedata_i[CTRL_PSRC_LSB +: 2] != ctrl_ff[CTRL_PSRC_LSB +: 2] &&
      avs_writedata_i[CTRL_PSRC_LSB +: 2] != SRC_BAD))));

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_fire && avs_address_i == REG_CTRL) begin
         if (avs_writedata_i[CTRL_FSEL_LSB +: 3] < IMO_NUM_FREQ) begin
            ctrl_ff[CTRL_FSEL_LSB +: 3] <= avs_writedata_i[CTRL_FSEL_LSB +: 3];
         end
         if (avs_writedata_i[CTRL_DSRC_LSB +: 2] != SRC_BAD) begin
            ctrl_ff[CTRL_DSRC_LSB +: 2] <= avs_writedata_i[CTRL_DSRC_LSB +: 2];
         end
         if (avs_writedata_i[CTRL_PSRC_LSB +: 2] != SRC_BAD) begin
            ctrl_ff[CTRL_PSRC_LSB +: 2] <= avs_writedata_i[CTRL_PSRC_LSB +: 2];
         end
         ctrl_ff[CTRL_PLL_EN] <= avs_writedata_i[CTRL_PLL_EN];
         ctrl_ff[CTRL_DBL_EN] <= avs_writedata_i[CTRL_DBL_EN];
      end
   end

   // feedback divider value zero is refused so 64 x 63 ratios remain
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pdiv_ff <= PDIV_RST;
      end else if (wr_fire && avs_address_i == REG_PLL_DIV) begin
         pdiv_ff[PDIV_IN_LSB +: 6] <= avs_writedata_i[PDIV_IN_LSB +: 6];
         if (avs_writedata_i[PDIV_FB_LSB +: 6] != 6'h00) begin
            pdiv_ff[PDIV_FB_LSB +: 6] <= avs_writedata_i[PDIV_FB_LSB +: 6];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         slow_cfg_ff <= SLOW_RST;
         fast_cfg_ff <= FAST_RST;
      end else if (wr_fire) begin
         if (avs_address_i == REG_SLOW_CFG) begin
            slow_cfg_ff <= {26'h000_0000, avs_writedata_i[5:0]};
         end
         if (avs_address_i == REG_FAST_CFG) begin
            fast_cfg_ff <= {25'h000_0000, avs_writedata_i[6:0]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < NUM_DIV; i++) begin
         if (!rst_n_i) begin
            div_ff[i] <= DIV_RST;
         end else if (wr_fire && avs_address_i == REG_DIV_BASE + 8'(4 * i)) begin
            div_ff[i] <= avs_writedata_i & 32'h8007_FFFF;
         end
      end
   end

   assign internal_main_osc_freq_sel_o = ctrl_ff[CTRL_FSEL_LSB +: 3];

   // ======================================================
   // source select for doubler and pll reference
   function automatic logic pick_src(input logic [1:0] s, input logic a,
      input logic b, input logic c);
      pick_src = (s == SRC_IMO) ? a : (s == SRC_FXTAL) ? b : (s == SRC_FABRIC) ? c : 1'b0;
   endfunction

   logic dbl_in;
   logic ref_in;
   assign dbl_in = pick_src(ctrl_ff[CTRL_DSRC_LSB +: 2], internal_main_osc_tick_i,
      fast_crystal_osc_tick_i, fabric_clk_tick_i);
   assign ref_in = pick_src(ctrl_ff[CTRL_PSRC_LSB +: 2], internal_main_osc_tick_i,
      fast_crystal_osc_tick_i, fabric_clk_tick_i);

   // ======================================================
   // doubler: a tick on each input edge plus one at half period
   logic [15:0] dbl_cnt_ff;
   logic [15:0] dbl_per_ff;
   logic dbl_tick_ff;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !ctrl_ff[CTRL_DBL_EN]) begin
         dbl_cnt_ff <= 16'h0000;
         dbl_per_ff <= 16'h0000;
         dbl_tick_ff <= 1'b0;
         dbl_act_ff <= 1'b0;
      end else if (dbl_in) begin
         dbl_per_ff <= dbl_cnt_ff + 16'h0001;
         dbl_cnt_ff <= 16'h0000;
         dbl_tick_ff <= 1'b1;
         dbl_act_ff <= 1'b1;
      end else begin
         if (dbl_cnt_ff != 16'hFFFF) begin
            dbl_cnt_ff <= dbl_cnt_ff + 16'h0001;
         end
         dbl_tick_ff <= (dbl_per_ff >= 16'h0002) && (dbl_cnt_ff + 16'h0001 == dbl_per_ff >> 1);
      end
   end
   assign doubler_tick_o = dbl_tick_ff;

   // ======================================================
   // pll: credit accumulator gives fb/in rate; lock after a fixed wait
   logic [7:0] credit_ff;
   logic pll_tick_ff;
   logic [15:0] lock_cnt_ff;
   logic [6:0] in_div;
   logic [7:0] credit_add;
   assign in_div = {1'b0, pdiv_ff[PDIV_IN_LSB +: 6]} + 7'h01;
   assign credit_add = (ref_in && !credit_ff[7]) ? {2'h0, pdiv_ff[PDIV_FB_LSB +: 6]} : 8'h00;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !ctrl_ff[CTRL_PLL_EN]) begin
         credit_ff <= 8'h00;
         pll_tick_ff <= 1'b0;
      end else if (credit_ff >= {1'b0, in_div}) begin
         credit_ff <= credit_ff - {1'b0, in_div} + credit_add;
         pll_tick_ff <= 1'b1;
      end else begin
         credit_ff <= credit_ff + credit_add;
         pll_tick_ff <= 1'b0;
      end
   end
   assign pll_tick_o = pll_tick_ff;

   // software must drop the enable before low power; lock then clears
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !ctrl_ff[CTRL_PLL_EN] || pll_restart) begin
         lock_cnt_ff <= 16'h0000;
         lock_ff <= 1'b0;
      end else if (lock_cnt_ff != LOCK_M) begin
         lock_cnt_ff <= lock_cnt_ff + 16'h0001;
         lock_ff <= (lock_cnt_ff + 16'h0001 == LOCK_M);
      end
   end
   assign pll_lock_o = lock_ff;

   // ======================================================
   // low-speed oscillator ticks
   logic [8:0] lso_cnt_ff;
   logic [6:0] slow_div_ff;
   logic [1:0] mid_div_ff;
   logic fast_ff;
   logic slow_ff;
   logic mid_ff;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lso_cnt_ff <= 9'h000;
         fast_ff <= 1'b0;
      end else begin
         lso_cnt_ff <= (lso_cnt_ff == FAST_DIV_M1) ? 9'h000 : lso_cnt_ff + 9'h001;
         fast_ff <= (lso_cnt_ff == FAST_DIV_M1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         slow_div_ff <= 7'h00;
         mid_div_ff <= 2'h0;
         slow_ff <= 1'b0;
         mid_ff <= 1'b0;
      end else begin
         slow_ff <= (lso_cnt_ff == FAST_DIV_M1) && (slow_div_ff == SLOW_DIV_M1);
         mid_ff <= (lso_cnt_ff == FAST_DIV_M1) && (mid_div_ff == MID_DIV_M1);
         if (lso_cnt_ff == FAST_DIV_M1) begin
            slow_div_ff <= (slow_div_ff == SLOW_DIV_M1) ? 7'h00 : slow_div_ff + 7'h01;
            mid_div_ff <= (mid_div_ff == MID_DIV_M1) ? 2'h0 : mid_div_ff + 2'h1;
         end
      end
   end
   assign low_speed_clk_fast_o = fast_ff;
   assign low_speed_clk_mid_o = mid_ff;
   assign low_speed_clk_slow_o = slow_ff;

   // ======================================================
   // slow wheel; period is 2^sel ticks for sel up to 13 (8192 ticks for sel 13 to 15), chosen as a power of two
   logic slow_run;
   logic slow_evt;
   logic [12:0] slow_mask;
   logic slow_wake_ff;
   logic slow_irq_ff;
   assign slow_run = slow_ff && !hibernate_i && !debug_halt_i;
   assign slow_mask = 13'((14'h0001 << slow_cfg_ff[SW_SEL_LSB +: 4]) - 14'h0001);
   assign slow_evt = slow_run && ((slow_cnt_ff & slow_mask) == slow_mask);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || slow_clr) begin
         slow_cnt_ff <= 13'h0000;
      end else if (slow_run) begin
         slow_cnt_ff <= slow_cnt_ff + 13'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         slow_wake_ff <= 1'b0;
         slow_irq_ff <= 1'b0;
      end else begin
         slow_wake_ff <= slow_evt && slow_cfg_ff[SW_WAKE_EN];
         slow_irq_ff <= slow_evt && slow_cfg_ff[SW_IRQ_EN];
      end
   end
   assign slow_wake_o = slow_wake_ff;
   assign slow_wake_irq_o = slow_irq_ff;

   // ======================================================
   // fast wheel
   logic fast_evt;
   logic fast_wake_ff;
   logic fast_irq_ff;
   assign fast_evt = fast_ff && (fast_cnt_ff == fast_cfg_ff[FW_TERM_LSB +: 5]);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fast_cnt_ff <= 5'h00;
      end else if (fast_ff) begin
         fast_cnt_ff <= fast_evt ? 5'h00 : fast_cnt_ff + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fast_wake_ff <= 1'b0;
         fast_irq_ff <= 1'b0;
      end else begin
         fast_wake_ff <= fast_evt && fast_cfg_ff[FW_WAKE_EN];
         fast_irq_ff <= fast_evt && fast_cfg_ff[FW_IRQ_EN];
      end
   end
   assign fast_wake_o = fast_wake_ff;
   assign fast_wake_irq_o = fast_irq_ff;

   // ======================================================
   // watch crystal: one-second time base
   logic [14:0] watch_cnt_ff;
   logic sec_ff;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         watch_cnt_ff <= 15'h0000;
         sec_ff <= 1'b0;
      end else begin
         sec_ff <= watch_crystal_osc_tick_i && (watch_cnt_ff == WATCH_M1);
         if (watch_crystal_osc_tick_i) begin
            watch_cnt_ff <= (watch_cnt_ff == WATCH_M1) ? 15'h0000 : watch_cnt_ff + 15'h0001;
         end
      end
   end
   assign rtc_second_irq_o = sec_ff;

   // ======================================================
   // clock dividers: 0..7 digital, 8..11 analog, 12 bus
   logic [NUM_DIV-1:0] div_clk;
   for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
      logic direct;
      assign direct = (g < NUM_DIG) ? fabric_div_clk_i[g % NUM_DIG] : 1'b0;
      cst_clk_div u_div (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .en_i(div_ff[g][DIV_EN]),
         .src_ticks_i({direct, watch_crystal_osc_tick_i, fast_ff, dbl_tick_ff,
            pll_tick_ff, fabric_clk_tick_i, fast_crystal_osc_tick_i,
            internal_main_osc_tick_i}),
         .sel_i(div_ff[g][DIV_SEL_LSB +: 3]),
         .div_i(div_ff[g][15:0]),
         .clk_o(div_clk[g]),
         .tick_o()
      );
   end
   assign dig_clk_o = div_clk[7:0];
   assign ana_clk_o = div_clk[11:8];
   assign bus_clk_o = div_clk[12];

   // ======================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   osc_sel_legal_a: assert property (internal_main_osc_freq_sel_o < IMO_NUM_FREQ)
      else $error("main oscillator code out of range");
   dbl_follow_a: assert property (ctrl_ff[CTRL_DBL_EN] && dbl_in |=> doubler_tick_o)
      else $error("doubler missed an input tick");
   lock_off_a: assert property (!ctrl_ff[CTRL_PLL_EN] |-> !pll_lock_o)
      else $error("lock shown while pll disabled");
   lock_restart_a: assert property (pll_restart |=> !pll_lock_o && lock_cnt_ff == 16'h0000)
      else $error("lock survived reconfiguration");
   lock_time_a: assert property (pll_lock_o |-> lock_cnt_ff == LOCK_M && ctrl_ff[CTRL_PLL_EN])
      else $error("lock at wrong count");
   mid_third_a: assert property (low_speed_clk_mid_o |-> low_speed_clk_fast_o && mid_div_ff == 2'h0)
      else $error("mid clock not a third of fast");
   slow_hold_a: assert property ((hibernate_i || debug_halt_i) && !slow_clr |=> $stable(slow_cnt_ff))
      else $error("slow wheel moved while halted");
   slow_clear_a: assert property (slow_clr |=> slow_cnt_ff == 13'h0000)
      else $error("slow wheel not cleared");
   fast_wrap_a: assert property (fast_evt |=> fast_cnt_ff == 5'h00)
      else $error("fast wheel did not wrap");
   fast_irq_a: assert property (fast_wake_irq_o |-> $past(fast_evt) && $past(fast_cfg_ff[FW_IRQ_EN]))
      else $error("fast interrupt without cause");
   bus_wait_a: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held beyond one cycle");

   lock_seen_c: cover property ($rose(pll_lock_o));
   fast_irq_c: cover property (fast_wake_irq_o);
   slow_wake_c: cover property (slow_wake_o);
   second_c: cover property (rtc_second_irq_o);
endmodule
`default_nettype wire

// [tb_clock_sources_and_timewheels.sv]
// bench for the clock source block: register checks, pll lock, fast wheel
// assumes cst_pkg and cst_clock_core are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_clock_sources_and_timewheels;
   import cst_pkg::*;
   // ======================================================
   // signals and design
   localparam int LOCK = 20; // short lock wait keeps the run brief
   logic clk_i = 0, rst_n_i = 0, rd = 0, wr = 0, irq, wake, fst, mid, lck;
   logic dbl, slo, swk, sirq;
   logic [1:0] halt = 2'h0;
   logic [7:0] adr = 8'h00, dclk;
   logic [3:0] tc = 4'h0;
   logic [31:0] wd = 32'h0000_0000, q, rdata;
   logic [2:0] fsel;
   logic avs_wait;
   int n_errors = 0, check_count = 0, cyc = 0, ni, nw, nf, nm, nd, nk;
   `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
      $display("CHECK FAILED %0t value mismatch", $time); end end
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) tc <= tc + 4'h1;
   cst_clock_core #(.LOCK_CYCLES(LOCK)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_readdata_o(rdata), .avs_waitrequest_o(avs_wait),
      .internal_main_osc_tick_i(tc[0]), .fast_crystal_osc_tick_i(tc[1:0] == 2'h0),
      .fabric_clk_tick_i(tc[2:0] == 3'h0), .fabric_div_clk_i({8{tc == 4'h0}}),
      .watch_crystal_osc_tick_i(tc == 4'hF), .hibernate_i(halt[0]), .debug_halt_i(halt[1]),
      .internal_main_osc_freq_sel_o(fsel), .doubler_tick_o(dbl), .pll_tick_o(),
      .pll_lock_o(lck), .low_speed_clk_slow_o(slo), .low_speed_clk_mid_o(mid),
      .low_speed_clk_fast_o(fst), .slow_wake_o(swk), .slow_wake_irq_o(sirq),
      .fast_wake_o(wake), .fast_wake_irq_o(irq), .rtc_second_irq_o(), .dig_clk_o(dclk),
      .ana_clk_o(), .bus_clk_o());
   // ======================================================
   // bus access: hold request until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk_i);
      end while (avs_wait !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   // count wheel pulses and low-speed ticks over a window of cycles
   task automatic watch(input int len);
      ni = 0; nw = 0; nf = 0; nm = 0; nd = 0; nk = 0;
      repeat (len) begin
         @(posedge clk_i);
         ni += int'(irq); nw += int'(wake); nf += int'(fst); nm += int'(mid);
         nd += int'(dbl); nk += int'(dclk[0]);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_errors++;
         conclude();
      end
   end
   // ======================================================
   // scenarios
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      bus(0, REG_CTRL, 0); `CHK(q, CTRL_RST)
      bus(0, REG_PLL_DIV, 0); `CHK(q, PDIV_RST)
      bus(0, REG_FAST_CFG, 0); `CHK(q, FAST_RST)
      bus(0, REG_DIV_BASE + 8'h30, 0); `CHK(q, DIV_RST)
      bus(0, 8'h3C, 0); `CHK(q, 32'h0000_0000)
      for (int f = 0; f < 7; f++) begin
         bus(1, REG_CTRL, f);
         bus(0, REG_CTRL, 0); `CHK(q[2:0], (f < 6) ? 3'(f) : 3'h5)
         `CHK(fsel, (f < 6) ? 3'(f) : 3'h5)
      end
      bus(1, REG_CTRL, 32'h0000_0035); bus(0, REG_CTRL, 0); `CHK(q[5:4], 2'h0)
      bus(1, REG_CTRL, 32'h0000_01C0); bus(0, REG_CTRL, 0); `CHK(q[7:6], 2'h0)
      bus(1, REG_CTRL, 32'h0000_0180); bus(0, REG_STATUS, 0); `CHK(q[0], 1'b0)
      repeat (LOCK + 4) @(posedge clk_i);
      bus(0, REG_STATUS, 0); `CHK(q[0], 1'b1)
      `CHK(lck, 1'b1)
      bus(1, REG_PLL_DIV, 32'h0000_0305); `CHK(lck, 1'b0)
      bus(1, REG_PLL_DIV, 32'h0000_0007); bus(0, REG_PLL_DIV, 0); `CHK(q, 32'h0000_0307)
      repeat (LOCK + 4) @(posedge clk_i);
      // source kept, only the enable drops
      bus(1, REG_CTRL, 32'h0000_0080);
      bus(0, REG_STATUS, 0); `CHK(q[0], 1'b0)
      // wheel wraps every terminal+1 ticks of 400 cycles; irq only when enabled
      bus(1, REG_FAST_CFG, 32'h0000_0022);
      watch(1300); `CHK(ni, 0)
      `CHK(nw, 1)
      bus(1, REG_FAST_CFG, 32'h0000_0062);
      while (irq !== 1'b1) @(posedge clk_i);
      watch(1200); `CHK(ni, 1)
      `CHK(nf, 3)
      `CHK(nm, 1)
      // doubler on main osc ticks, digital divider 0 on its direct fabric clock
      bus(1, REG_CTRL, 32'h0000_0200);
      bus(1, REG_DIV_BASE, 32'h8007_0002);
      watch(40);
      watch(320); `CHK(nd, 320)
      `CHK(nk, 160)
      bus(0, REG_STATUS, 0); `CHK(q[1], 1'b1)
      // slow wheel: one 1 kHz tick held off, then one counted
      bus(1, REG_SLOW_CFG, 32'h0000_0030);
      halt <= 2'b11;
      while (slo !== 1'b1) @(posedge clk_i);
      @(posedge clk_i); `CHK(swk | sirq, 1'b0)
      bus(0, REG_COUNT, 0); `CHK(q[12:0], 13'h0000)
      halt <= 2'b00;
      while (slo !== 1'b1) @(posedge clk_i);
      @(posedge clk_i); `CHK(swk & sirq, 1'b1)
      bus(0, REG_COUNT, 0); `CHK(q[12:0], 13'h0001)
      bus(1, REG_SLOW_CFG, 32'h0000_0130);
      bus(0, REG_COUNT, 0); `CHK(q[12:0], 13'h0000)
      conclude();
   end
endmodule
`default_nettype wire
